// ---- hw/msc_pkg.sv ----
/*
 Package for the message signaled interrupt block: register offsets, field
 positions, reset values and the carrier structs shared by its ports.
 Assumes a configuration access path that presents byte addresses of dwords.
*/
package msc_pkg;

   localparam logic [7:0]  MSC_CONTROL_OFFSET      = 8'h4a;
   localparam logic [7:0]  MSC_ADDR_LOW_OFFSET     = 8'h4c;
   localparam logic [7:0]  MSC_ADDR_HIGH_OFFSET    = 8'h50;
   localparam logic [7:0]  MSC_DWORD_48_OFFSET     = 8'h48;

   localparam int          MSC_VEC_MASK_BIT        = 8;
   localparam int          MSC_WIDE_ADDR_BIT       = 7;
   localparam int          MSC_COUNT_EN_LSB        = 4;
   localparam int          MSC_COUNT_CAP_LSB       = 1;
   localparam int          MSC_ENABLE_BIT          = 0;

   localparam logic [2:0]  MSC_COUNT_CAP_VALUE     = 3'h3;
   localparam logic [2:0]  MSC_COUNT_EN_MAX        = 3'h5;
   localparam logic [2:0]  MSC_COUNT_EN_RESET      = 3'h0;
   localparam logic        MSC_ENABLE_RESET        = 1'h0;
   localparam logic [29:0] MSC_ADDR_LOW_RESET      = 30'h0;
   localparam logic [31:0] MSC_ADDR_HIGH_RESET     = 32'h0;

   localparam int          MSC_INTERRUPTERS        = 8;

   typedef struct packed {
      logic        write;
      logic        read;
      logic [7:0]  address;
      logic [3:0]  byte_enable;
      logic [31:0] write_data;
   } msc_cfg_req_type;

   typedef struct packed {
      logic        valid;
      logic        wide;
      logic [63:0] address;
      logic [15:0] data;
   } msc_message_type;

endpackage

// ---- hw/msc_signaling.sv ----
/*
 Message signaled interrupt capability: control, lower and upper address
 registers, interrupter to message mapping and message write issue.
 Assumes configuration requests arrive as one-cycle strobes on sys_clk_in and
 that the message write engine accepts one message per cycle when ready.
*/
`timescale 1ns/1ps

module msc_signaling
   import msc_pkg::*;
#(
   parameter int INTERRUPTERS = MSC_INTERRUPTERS
)
(
   // Clock and reset.
   input  wire logic                    sys_clk_in,
   input  wire logic                    reset_in,
   // Configuration access.
   input  wire msc_cfg_req_type         cfg_req_in,
   output logic [31:0]                  cfg_read_data_out,
   output logic                         cfg_read_valid_out,
   // Interrupt requests and message data.
   input  wire logic [INTERRUPTERS-1:0] interrupter_request_in,
   input  wire logic [15:0]             fixed_message_bits_in,
   // Message write engine.
   input  wire logic                    message_ready_in,
   output msc_message_type              message_out,
   output logic                         message_interrupt_enable_out
);

   logic [2:0]              message_count_enabled_reg;
   logic [2:0]              message_count_enabled_next;
   logic                    message_interrupt_enable_reg;
   logic                    message_interrupt_enable_next;
   logic [29:0]             address_low_reg;
   logic [29:0]             address_low_next;
   logic [31:0]             address_high_reg;
   logic [31:0]             address_high_next;
   logic [INTERRUPTERS-1:0] pending_reg;
   logic [INTERRUPTERS-1:0] pending_next;
   logic [31:0]             read_data_reg;
   logic [31:0]             read_data_next;
   logic                    read_valid_reg;
   logic                    read_valid_next;
   msc_message_type         message_reg;
   msc_message_type         message_next;
   logic [15:0]             control_value;
   logic                    write_hit_ctrl;
   logic                    write_hit_low;
   logic                    write_hit_high;

   // The control word shares the dword at 48h with the fixed capability bytes, which other logic owns.
   // Reserved bits of the control word read zero.
   always_comb
   begin
      control_value                        = 16'h0000;
      control_value[MSC_VEC_MASK_BIT]      = 1'b0;
      control_value[MSC_WIDE_ADDR_BIT]     = 1'b1;
      control_value[MSC_COUNT_EN_LSB +: 3] = message_count_enabled_reg;
      control_value[MSC_COUNT_CAP_LSB +: 3] = MSC_COUNT_CAP_VALUE;
      control_value[MSC_ENABLE_BIT]        = message_interrupt_enable_reg;
   end

   // Only exact dword addresses decode; the control halfword is reached through its dword.
   assign write_hit_ctrl = cfg_req_in.write && (cfg_req_in.address == MSC_DWORD_48_OFFSET);
   assign write_hit_low  = cfg_req_in.write && (cfg_req_in.address == MSC_ADDR_LOW_OFFSET);
   assign write_hit_high = cfg_req_in.write && (cfg_req_in.address == MSC_ADDR_HIGH_OFFSET);

   // Register writes and reads.
   always_comb
   begin
      message_count_enabled_next    = message_count_enabled_reg;
      message_interrupt_enable_next = message_interrupt_enable_reg;
      address_low_next              = address_low_reg;
      address_high_next             = address_high_reg;
      read_data_next                = read_data_reg;
      read_valid_next               = cfg_req_in.read;
      if (write_hit_ctrl && cfg_req_in.byte_enable[2])
      begin
         message_interrupt_enable_next = cfg_req_in.write_data[16 + MSC_ENABLE_BIT];
         // Reserved codes are refused so the mapping below never sees them.
         if (cfg_req_in.write_data[16 + MSC_COUNT_EN_LSB +: 3] <= MSC_COUNT_EN_MAX)
         begin
            message_count_enabled_next = cfg_req_in.write_data[16 + MSC_COUNT_EN_LSB +: 3];
         end
      end
      if (write_hit_low)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (cfg_req_in.byte_enable[b])
            begin
               for (int i = 8 * b; i < 8 * b + 8; i++)
               begin
                  if (i >= 2)
                  begin
                     address_low_next[i-2] = cfg_req_in.write_data[i];
                  end
               end
            end
         end
      end
      if (write_hit_high)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (cfg_req_in.byte_enable[b])
            begin
               address_high_next[8*b +: 8] = cfg_req_in.write_data[8*b +: 8];
            end
         end
      end
      if (cfg_req_in.read)
      begin
         unique case (cfg_req_in.address)
            MSC_DWORD_48_OFFSET:  read_data_next = {control_value, 16'h0000};
            MSC_ADDR_LOW_OFFSET:  read_data_next = {address_low_reg, 2'b00};
            MSC_ADDR_HIGH_OFFSET: read_data_next = address_high_reg;
            default:              read_data_next = 32'h0000_0000;
         endcase
      end
   end

   // Pending interrupters and message issue, lowest interrupter first.
   always_comb
   begin
      logic [2:0] winner;
      logic       found;
      logic [2:0] number;
      winner       = 3'h0;
      found        = 1'b0;
      number       = 3'h0;
      pending_next = pending_reg | interrupter_request_in;
      message_next = message_reg;
      if (message_reg.valid && message_ready_in)
      begin
         message_next.valid = 1'b0;
      end
      // Counting down leaves the lowest pending interrupter as the winner.
      for (int i = INTERRUPTERS - 1; i >= 0; i--)
      begin
         if (pending_reg[i])
         begin
            winner = 3'(i);
            found  = 1'b1;
         end
      end
      // A message already held keeps its number; enable changes affect only the next one.
      if (message_interrupt_enable_reg && found && !message_next.valid)
      begin
         // Sixteen or thirty-two messages still use three number bits, as only eight interrupters exist.
         unique case (message_count_enabled_reg)
            3'h0:    number = 3'h0;
            3'h1:    number = {2'b00, winner[0]};
            3'h2:    number = {1'b0, winner[1:0]};
            default: number = winner;
         endcase
         message_next.valid   = 1'b1;
         message_next.address = {address_high_reg, address_low_reg, 2'b00};
         message_next.wide    = (address_high_reg != 32'h0000_0000);
         message_next.data    = fixed_message_bits_in;
         // Only as many low bits as the enabled count needs, at most three, are replaced.
         for (int k = 0; k < 3; k++)
         begin
            if (32'(k) < 32'(message_count_enabled_reg))
            begin
               message_next.data[k] = number[k];
            end
         end
         // A request arriving now for the same interrupter stays pending.
         pending_next[winner] = interrupter_request_in[winner];
      end
   end

   // Reset is synchronous, so every register loads a constant on the clock edge.
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         message_count_enabled_reg    <= MSC_COUNT_EN_RESET;
         message_interrupt_enable_reg <= MSC_ENABLE_RESET;
         address_low_reg              <= MSC_ADDR_LOW_RESET;
         address_high_reg             <= MSC_ADDR_HIGH_RESET;
         pending_reg                  <= '0;
         read_data_reg                <= 32'h0000_0000;
         read_valid_reg               <= 1'b0;
         message_reg                  <= '0;
      end
      else
      begin
         message_count_enabled_reg    <= message_count_enabled_next;
         message_interrupt_enable_reg <= message_interrupt_enable_next;
         address_low_reg              <= address_low_next;
         address_high_reg             <= address_high_next;
         pending_reg                  <= pending_next;
         read_data_reg                <= read_data_next;
         read_valid_reg               <= read_valid_next;
         message_reg                  <= message_next;
      end
   end

   // Outputs come straight from registers so the write engine sees no decode glitches.
   assign cfg_read_data_out            = read_data_reg;
   assign cfg_read_valid_out           = read_valid_reg;
   assign message_out                  = message_reg;
   assign message_interrupt_enable_out = message_interrupt_enable_reg;

endmodule

// ---- tb/msc_host_model.sv ----
/* Receiver of message writes, standing for the root complex.
   Assumes messages are offered with valid held until accepted. */
`timescale 1ns/1ps
module msc_host_model
   import msc_pkg::*;
(
   // Clock, reset, stall control and message traffic.
   input  wire logic            sys_clk_in,
   input  wire logic            reset_in,
   input  wire logic            stall_in,
   input  wire msc_message_type message_in,
   output logic                 ready_out,
   output msc_message_type      got_out,
   output logic [7:0]           got_cnt_out
);
   // Ready changes only after an edge, so a stall never cuts a message in half.
   always_ff @(posedge sys_clk_in)
   begin
      ready_out <= !stall_in && !reset_in;
      if (reset_in)
         got_cnt_out <= 8'h00;
      else if (message_in.valid && ready_out)
      begin
         got_out     <= message_in;
         got_cnt_out <= got_cnt_out + 8'h01;
      end
   end
endmodule

// ---- tb/msc_signaling_monitor.sv ----
/* Port checker for the message interrupt block.
   Assumes binding to msc_signaling and reads answered one cycle after the strobe. */
`timescale 1ns/1ps
module msc_signaling_monitor
   import msc_pkg::*;
#(parameter int INTERRUPTERS = MSC_INTERRUPTERS)
(
   // Clock, reset and configuration.
   input wire logic                    sys_clk_in,
   input wire logic                    reset_in,
   input wire msc_cfg_req_type         cfg_req_in,
   input wire logic [31:0]             cfg_read_data_out,
   input wire logic                    cfg_read_valid_out,
   // Interrupts and messages.
   input wire logic [INTERRUPTERS-1:0] interrupter_request_in,
   input wire logic [15:0]             fixed_message_bits_in,
   input wire logic                    message_ready_in,
   input wire msc_message_type         message_out,
   input wire logic                    message_interrupt_enable_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   sequence ctl_rd_seq;
      cfg_req_in.read && cfg_req_in.address == MSC_DWORD_48_OFFSET;
   endsequence
   sequence low_rd_seq;
      cfg_req_in.read && cfg_req_in.address == MSC_ADDR_LOW_OFFSET;
   endsequence
   AST_VEC_MASK: assert property (ctl_rd_seq |=> cfg_read_data_out[24] == 1'b0)
      else $error("vector mask capability not zero");
   AST_WIDE_CAP: assert property (ctl_rd_seq |=> cfg_read_data_out[23] == 1'b1)
      else $error("wide address capability not one");
   AST_COUNT_CAP: assert property (ctl_rd_seq |=> cfg_read_data_out[19:17] == 3'h3)
      else $error("message count capability wrong");
   AST_LOW_ALIGN: assert property (low_rd_seq |=> cfg_read_valid_out && cfg_read_data_out[1:0] == 2'h0)
      else $error("low address bits not zero");
   AST_GATE: assert property ($rose(message_out.valid) |-> message_interrupt_enable_out)
      else $error("message raised while disabled");
   AST_ADDR_ALIGN: assert property (message_out.valid |-> message_out.address[1:0] == 2'h0)
      else $error("message address not dword aligned");
   AST_WIDE_SEL: assert property (message_out.valid |->
      message_out.wide == (message_out.address[63:32] != 32'h0))
      else $error("message width select wrong");
   AST_DATA_KEEP: assert property (message_out.valid |->
      message_out.data[15:3] == fixed_message_bits_in[15:3])
      else $error("fixed message bits altered");
   AST_HOLD: assert property (message_out.valid && !message_ready_in |=>
      message_out.valid && $stable(message_out))
      else $error("message dropped before acceptance");
endmodule
bind msc_signaling msc_signaling_monitor #(.INTERRUPTERS(INTERRUPTERS)) msc_signaling_monitor_inst (.sys_clk_in,
   .reset_in, .cfg_req_in, .cfg_read_data_out, .cfg_read_valid_out, .interrupter_request_in, .fixed_message_bits_in,
   .message_ready_in, .message_out, .message_interrupt_enable_out);

// ---- tb/tb_top.sv ----
/* Testbench: configuration accesses, interrupt requests and message checks.
   Assumes a host model that accepts the block's message writes. */
`timescale 1ns/1ps
module tb_top;
   import msc_pkg::*;
   logic            sys_clk_in = 1'b0;
   logic            reset_in   = 1'b1;
   msc_cfg_req_type cfg_req    = '0;
   logic [7:0]      irq        = 8'h00;
   logic [15:0]     fixed      = 16'ha5a5;
   logic            stall      = 1'b0;
   logic [31:0]     rd_data, seen;
   logic            rd_valid, ready, en_out;
   msc_message_type message, got;
   logic [7:0]      got_cnt;
   logic [15:0]     num, mask;
   int              error_cnt = 0;
   int              n_tests   = 0;
   msc_signaling msc_signaling_inst (.sys_clk_in, .reset_in, .cfg_req_in(cfg_req), .cfg_read_data_out(rd_data),
      .cfg_read_valid_out(rd_valid), .interrupter_request_in(irq), .fixed_message_bits_in(fixed),
      .message_ready_in(ready), .message_out(message), .message_interrupt_enable_out(en_out));
   msc_host_model msc_host_model_inst (.sys_clk_in, .reset_in, .stall_in(stall), .message_in(message),
      .ready_out(ready), .got_out(got), .got_cnt_out(got_cnt));
   initial
   begin
      forever #5 sys_clk_in = ~sys_clk_in;
   end
   task check(input string name, input logic [63:0] seen_v, input logic [63:0] exp);
      n_tests++;
      if (seen_v !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen_v);
      end
   endtask
   task finish_test;
      if (error_cnt == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(negedge sys_clk_in) cfg_req = '{1'b1, 1'b0, a, be, d};
      @(negedge sys_clk_in) cfg_req = '0;
   endtask
   task cfg_read(input logic [7:0] a);
      @(negedge sys_clk_in) cfg_req = '{1'b0, 1'b1, a, 4'hf, 32'h0};
      @(negedge sys_clk_in) cfg_req = '0;
      check("read valid", rd_valid, 1'b1);
      seen = rd_data;
   endtask
   // Waits three cycles before releasing any stall the caller set; ready_out follows stall one edge later, so messages offered while ready_out is low must wait.
   task take_message(input logic [7:0] c0, input logic [15:0] exp, input logic [63:0] adr, input logic wide);
      int k;
      k = 0;
      repeat (3) @(negedge sys_clk_in);
      stall = 1'b0;
      while (got_cnt == c0 && k < 50)
      begin
         @(negedge sys_clk_in);
         k++;
      end
      check("message count", got_cnt, c0 + 8'h01);
      check("message data", got.data, exp);
      check("message address", got.address, adr);
      check("message wide", got.wide, wide);
   endtask
   initial
   begin
      repeat (2) @(negedge sys_clk_in);
      reset_in = 1'b0;
      cfg_read(MSC_DWORD_48_OFFSET);
      check("control reset", seen[31:16], 16'h0086);
      cfg_read(MSC_ADDR_HIGH_OFFSET);
      check("high reset", seen, 32'h0);
      cfg_write(MSC_ADDR_LOW_OFFSET, 4'hf, 32'h1234_567b);
      cfg_read(MSC_ADDR_LOW_OFFSET);
      check("low address", seen, 32'h1234_5678);
      stall = 1'b1;
      @(negedge sys_clk_in) irq = 8'h08;
      @(negedge sys_clk_in) irq = 8'h00;
      repeat (8) @(negedge sys_clk_in);
      check("gated message", {got_cnt, message.valid}, 9'h0);
      cfg_write(MSC_DWORD_48_OFFSET, 4'h4, 32'h0031_0000);
      take_message(8'h00, 16'ha5a3, 64'h1234_5678, 1'b0);
      cfg_write(MSC_ADDR_HIGH_OFFSET, 4'hf, 32'h0000_0001);
      for (int c = 0; c < 6; c++)
      begin
         cfg_write(MSC_DWORD_48_OFFSET, 4'h4, 32'h0001_0000 | (c << 20));
         for (int i = 0; i < 8; i++)
         begin
            num  = (c == 0) ? 16'h0 : (c == 1) ? 16'(i & 1) : (c == 2) ? 16'(i & 3) : 16'(i);
            mask = (c == 0) ? 16'h0 : (c == 1) ? 16'h1 : (c == 2) ? 16'h3 : 16'h7;
            stall = i[0];
            @(negedge sys_clk_in) irq = 8'h01 << i;
            @(negedge sys_clk_in) irq = 8'h00;
            take_message(got_cnt, (fixed & ~mask) | (num & mask), 64'h1_1234_5678, 1'b1);
         end
      end
      cfg_write(MSC_DWORD_48_OFFSET, 4'h4, 32'h0061_0000);
      cfg_read(MSC_DWORD_48_OFFSET);
      check("reserved count", seen[31:16], 16'h00d7);
      cfg_write(MSC_DWORD_48_OFFSET, 4'h4, 32'h0);
      check("enable off", en_out, 1'b0);
      finish_test();
   end
   initial
   begin
      #50000;
      error_cnt++;
      finish_test();
   end
endmodule
